//--- rtl/nbu_pkg.sv
// Constants, register map and state encodings of the nine-bit serial port
package nbu_pkg;

    // Register byte addresses on the AXI4-Lite bus
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_MASK   = 8'h08;
    localparam logic [7:0] ADDR_DATA   = 8'h0C;
    localparam logic [7:0] ADDR_RXINFO = 8'h10;
    localparam logic [7:0] ADDR_BAUD   = 8'h14;

    // Field positions
    localparam int CTRL_RX_EN    = 0;
    localparam int CTRL_MP_FILT  = 1;
    localparam int CTRL_TX_NINTH = 2;
    localparam int STAT_TX_DONE  = 0;
    localparam int STAT_RX_DONE  = 1;
    localparam int INFO_RX_NINTH = 0;
    localparam int INFO_TX_BUSY  = 1;

    // Values after reset
    localparam logic [2:0]  CTRL_RESET = 3'h0;
    localparam logic [1:0]  MASK_RESET = 2'h0;
    localparam logic [15:0] BAUD_RESET = 16'h0036;

    // Bit timing: sixteen oversample ticks per bit, nine data bits
    localparam logic [3:0] OS_LAST  = 4'hF;
    localparam logic [3:0] OS_HALF  = 4'h7;
    localparam logic [3:0] BIT_LAST = 4'h8;

    // AXI response codes
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Frame sequencer states, shared by transmitter and receiver
    typedef enum logic [3:0] {
        SEQ_IDLE  = 4'b0001,
        SEQ_START = 4'b0010,
        SEQ_DATA  = 4'b0100,
        SEQ_STOP  = 4'b1000
    } nbu_seq_type;

endpackage

//--- rtl/nbu_rx.sv
// Frame receiver with acceptance filter
`timescale 1ns/10ps
module nbu_rx (
    input  wire logic aclk,    // System clock
    input  wire logic aresetn, // Synchronous reset, low
    input  wire logic rxd,     // Serial line in
    nbu_rx_if.rx      bus      // Link to the core
);

    typedef struct packed {
        nbu_pkg::nbu_seq_type state;
        logic [3:0]           tick;
        logic [3:0]           bitn;
        logic [8:0]           shift;
        logic                 accept;
        logic [7:0]           data;
        logic                 ninth;
    } nbu_rx_state_type;

    nbu_rx_state_type s;
    nbu_rx_state_type n;

    // Frame sequencing, sampling at mid bit
    always_comb
    begin
        n = s;
        n.accept = 1'b0;
        unique case (s.state)
            nbu_pkg::SEQ_IDLE:
            begin
                if (bus.rx_enable && !rxd)
                begin
                    n.state = nbu_pkg::SEQ_START;
                    n.tick  = 4'h0;
                end
            end
            nbu_pkg::SEQ_START:
            begin
                if (bus.os_tick && s.tick == nbu_pkg::OS_HALF)
                begin
                    n.tick  = 4'h0;
                    n.bitn  = 4'h0;
                    n.state = rxd ? nbu_pkg::SEQ_IDLE : nbu_pkg::SEQ_DATA;
                end
                else if (bus.os_tick)
                    n.tick = s.tick + 4'h1;
            end
            nbu_pkg::SEQ_DATA:
            begin
                if (bus.os_tick && s.tick == nbu_pkg::OS_LAST)
                begin
                    n.tick  = 4'h0;
                    n.shift = {rxd, s.shift[8:1]}; // LSB first
                    n.bitn  = s.bitn + 4'h1;
                    if (s.bitn == nbu_pkg::BIT_LAST)
                        n.state = nbu_pkg::SEQ_STOP;
                end
                else if (bus.os_tick)
                    n.tick = s.tick + 4'h1;
            end
            nbu_pkg::SEQ_STOP:
            begin
                // Stop level is not looked at
                if (bus.os_tick && s.tick == nbu_pkg::OS_LAST)
                begin
                    n.state = nbu_pkg::SEQ_IDLE;
                    n.tick  = 4'h0;
                    if (!bus.done_flag &&
                        (!bus.mp_filter || s.shift[8]))
                    begin
                        n.accept = 1'b1;
                        n.data   = s.shift[7:0];
                        n.ninth  = s.shift[8];
                    end
                end
                else if (bus.os_tick)
                    n.tick = s.tick + 4'h1;
            end
        endcase
    end

    // State register
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s       <= '0;
            s.state <= nbu_pkg::SEQ_IDLE;
        end
        else
            s <= n;
    end

    // Outputs toward the core
    assign bus.accept = s.accept;
    assign bus.data   = s.data;
    assign bus.ninth  = s.ninth;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // Acceptance only with free buffer and passing filter
    a_accept_gate: assert property (
        s.accept |-> !$past(bus.done_flag) &&
                     (!$past(bus.mp_filter) || s.ninth))
        else $error("frame accepted against filter or full buffer");

    // Disabled receiver stays idle
    a_idle_disabled: assert property (
        (s.state == nbu_pkg::SEQ_IDLE && !bus.rx_enable)
        |=> s.state == nbu_pkg::SEQ_IDLE)
        else $error("receiver left idle while disabled");

endmodule

//--- rtl/nbu_rx_if.sv
// Link between the register core and the frame receiver
`timescale 1ns/10ps
interface nbu_rx_if;
    logic       os_tick;
    logic       rx_enable;
    logic       mp_filter;
    logic       done_flag;
    logic       accept;
    logic       ninth;
    logic [7:0] data;

    modport core (output os_tick, rx_enable, mp_filter, done_flag,
                  input accept, ninth, data);
    modport rx   (input os_tick, rx_enable, mp_filter, done_flag,
                  output accept, ninth, data);
endinterface

//--- rtl/nbu_top.sv
// Nine-bit serial port with AXI4-Lite registers and interrupt
`timescale 1ns/10ps
module nbu_top (
    input  wire logic        aclk,          // System clock, 100 MHz
    input  wire logic        aresetn,       // Synchronous reset, low
    input  wire logic [7:0]  s_axi_awaddr,  // Write address
    input  wire logic        s_axi_awvalid, // Write address valid
    output logic             s_axi_awready, // Write address ready
    input  wire logic [31:0] s_axi_wdata,   // Write data
    input  wire logic [3:0]  s_axi_wstrb,   // Write byte strobes
    input  wire logic        s_axi_wvalid,  // Write data valid
    output logic             s_axi_wready,  // Write data ready
    output logic [1:0]       s_axi_bresp,   // Write response
    output logic             s_axi_bvalid,  // Write response valid
    input  wire logic        s_axi_bready,  // Write response ready
    input  wire logic [7:0]  s_axi_araddr,  // Read address
    input  wire logic        s_axi_arvalid, // Read address valid
    output logic             s_axi_arready, // Read address ready
    output logic [31:0]      s_axi_rdata,   // Read data
    output logic [1:0]       s_axi_rresp,   // Read response
    output logic             s_axi_rvalid,  // Read data valid
    input  wire logic        s_axi_rready,  // Read data ready
    input  wire logic        rxd,           // Serial line in
    output logic             txd,           // Serial line out
    output logic             irq            // Interrupt, high level
);

    typedef struct packed {
        logic                 awready;
        logic                 wready;
        logic                 bvalid;
        logic                 arready;
        logic                 rvalid;
        logic                 aw_got;
        logic                 w_got;
        logic [7:0]           awaddr;
        logic [31:0]          wdata;
        logic [3:0]           wstrb;
        logic [1:0]           bresp;
        logic [1:0]           rresp;
        logic [31:0]          rdata;
        logic [2:0]           ctrl;
        logic [1:0]           status;
        logic [1:0]           mask;
        logic [15:0]          baud;
        logic [15:0]          os_cnt;
        logic                 os_tick;
        logic [7:0]           rx_buf;
        logic                 rx_ninth;
        nbu_pkg::nbu_seq_type tx_state;
        logic [3:0]           tx_tick;
        logic [3:0]           tx_bit;
        logic [8:0]           tx_shift;
        logic                 tx_ninth;
        logic                 txd;
        logic                 irq;
    } nbu_top_state_type;

    nbu_top_state_type s;
    nbu_top_state_type n;
    logic              tx_load;
    logic              tx_set;
    logic [1:0]        stat_clr;
    logic              tx_busy;

    nbu_rx_if bus ();

    // Receiver instance
    nbu_rx u_rx (
        .aclk    (aclk),
        .aresetn (aresetn),
        .rxd     (rxd),
        .bus     (bus.rx)
    );

    assign tx_busy = (s.tx_state != nbu_pkg::SEQ_IDLE);

    // Next state of bus slave, registers, divider and transmitter
    always_comb
    begin
        n        = s;
        tx_load  = 1'b0;
        tx_set   = 1'b0;
        stat_clr = 2'h0;

        // Oversample divider, one tick every baud plus one cycles
        n.os_tick = 1'b0;
        if (s.os_cnt >= s.baud)
        begin
            n.os_cnt  = 16'h0000;
            n.os_tick = 1'b1;
        end
        else
            n.os_cnt = s.os_cnt + 16'h0001;

        // Write address and data, taken in either order
        if (s_axi_awvalid && s.awready)
        begin
            n.aw_got = 1'b1;
            n.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s.wready)
        begin
            n.w_got = 1'b1;
            n.wdata = s_axi_wdata;
            n.wstrb = s_axi_wstrb;
        end
        if (s.bvalid && s_axi_bready)
            n.bvalid = 1'b0;

        // Register write once both halves are held
        if (s.aw_got && s.w_got && !s.bvalid)
        begin
            n.aw_got = 1'b0;
            n.w_got  = 1'b0;
            n.bvalid = 1'b1;
            n.bresp  = nbu_pkg::RESP_OKAY;
            case (s.awaddr)
                nbu_pkg::ADDR_CTRL:
                begin
                    if (s.wstrb[0])
                        n.ctrl = s.wdata[2:0];
                end
                nbu_pkg::ADDR_STATUS:
                begin
                    if (s.wstrb[0])
                        stat_clr = s.wdata[1:0];
                end
                nbu_pkg::ADDR_MASK:
                begin
                    if (s.wstrb[0])
                        n.mask = s.wdata[1:0];
                end
                nbu_pkg::ADDR_DATA:
                begin
                    tx_load = s.wstrb[0];
                end
                nbu_pkg::ADDR_RXINFO:
                begin
                    n.bresp = nbu_pkg::RESP_OKAY;
                end
                nbu_pkg::ADDR_BAUD:
                begin
                    if (s.wstrb[0])
                        n.baud[7:0] = s.wdata[7:0];
                    if (s.wstrb[1])
                        n.baud[15:8] = s.wdata[15:8];
                end
                default:
                begin
                    n.bresp = nbu_pkg::RESP_SLVERR;
                end
            endcase
        end

        // Read channel, answered one cycle after the address
        if (s.rvalid && s_axi_rready)
            n.rvalid = 1'b0;
        if (s_axi_arvalid && s.arready)
        begin
            n.rvalid = 1'b1;
            n.rresp  = nbu_pkg::RESP_OKAY;
            n.rdata  = 32'h00000000;
            case (s_axi_araddr)
                nbu_pkg::ADDR_CTRL:
                    n.rdata[2:0] = s.ctrl;
                nbu_pkg::ADDR_STATUS:
                    n.rdata[1:0] = s.status;
                nbu_pkg::ADDR_MASK:
                    n.rdata[1:0] = s.mask;
                nbu_pkg::ADDR_DATA:
                    n.rdata[7:0] = s.rx_buf;
                nbu_pkg::ADDR_RXINFO:
                begin
                    n.rdata[nbu_pkg::INFO_RX_NINTH] = s.rx_ninth;
                    n.rdata[nbu_pkg::INFO_TX_BUSY]  = tx_busy;
                end
                nbu_pkg::ADDR_BAUD:
                    n.rdata[15:0] = s.baud;
                default:
                    n.rresp = nbu_pkg::RESP_SLVERR;
            endcase
        end

        // Transmit sequencer, a write while busy is dropped
        unique case (s.tx_state)
            nbu_pkg::SEQ_IDLE:
            begin
                n.txd = 1'b1;
                if (tx_load)
                begin
                    n.tx_ninth = s.ctrl[nbu_pkg::CTRL_TX_NINTH];
                    n.tx_shift = {s.ctrl[nbu_pkg::CTRL_TX_NINTH],
                                  s.wdata[7:0]};
                    n.tx_tick  = 4'h0;
                    n.tx_state = nbu_pkg::SEQ_START;
                    n.txd      = 1'b0; // Start bit
                end
            end
            nbu_pkg::SEQ_START:
            begin
                if (s.os_tick && s.tx_tick == nbu_pkg::OS_LAST)
                begin
                    n.tx_tick  = 4'h0;
                    n.tx_bit   = 4'h0;
                    n.tx_state = nbu_pkg::SEQ_DATA;
                    n.txd      = s.tx_shift[0];
                end
                else if (s.os_tick)
                    n.tx_tick = s.tx_tick + 4'h1;
            end
            nbu_pkg::SEQ_DATA:
            begin
                if (s.os_tick && s.tx_tick == nbu_pkg::OS_LAST)
                begin
                    n.tx_tick = 4'h0;
                    if (s.tx_bit == nbu_pkg::BIT_LAST)
                    begin
                        n.tx_state = nbu_pkg::SEQ_STOP;
                        n.txd      = 1'b1; // Stop bit
                        tx_set     = 1'b1;
                    end
                    else
                    begin
                        n.tx_bit   = s.tx_bit + 4'h1;
                        n.tx_shift = {1'b0, s.tx_shift[8:1]};
                        n.txd      = s.tx_shift[1]; // LSB first
                    end
                end
                else if (s.os_tick)
                    n.tx_tick = s.tx_tick + 4'h1;
            end
            nbu_pkg::SEQ_STOP:
            begin
                if (s.os_tick && s.tx_tick == nbu_pkg::OS_LAST)
                begin
                    n.tx_tick  = 4'h0;
                    n.tx_state = nbu_pkg::SEQ_IDLE;
                end
                else if (s.os_tick)
                    n.tx_tick = s.tx_tick + 4'h1;
            end
        endcase

        // Receive buffer loads only on an accepted frame
        if (bus.accept)
        begin
            n.rx_buf   = bus.data;
            n.rx_ninth = bus.ninth;
        end

        // Sticky flags, a set wins over a write-one clear
        n.status = (s.status & ~stat_clr) |
                   {bus.accept, tx_set};

        // Interrupt level and channel readies
        n.irq     = |(n.status & n.mask);
        n.awready = !n.aw_got && !n.bvalid;
        n.wready  = !n.w_got && !n.bvalid;
        n.arready = !n.rvalid;
    end

    // State register
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s          <= '0;
            s.ctrl     <= nbu_pkg::CTRL_RESET;
            s.mask     <= nbu_pkg::MASK_RESET;
            s.baud     <= nbu_pkg::BAUD_RESET;
            s.tx_state <= nbu_pkg::SEQ_IDLE;
            s.txd      <= 1'b1;
        end
        else
            s <= n;
    end

    // Outputs straight from the state register
    assign s_axi_awready = s.awready;
    assign s_axi_wready  = s.wready;
    assign s_axi_bvalid  = s.bvalid;
    assign s_axi_bresp   = s.bresp;
    assign s_axi_arready = s.arready;
    assign s_axi_rvalid  = s.rvalid;
    assign s_axi_rdata   = s.rdata;
    assign s_axi_rresp   = s.rresp;
    assign txd           = s.txd;
    assign irq           = s.irq;

    // Core side of the receiver link
    assign bus.os_tick   = s.os_tick;
    assign bus.rx_enable = s.ctrl[nbu_pkg::CTRL_RX_EN];
    assign bus.mp_filter = s.ctrl[nbu_pkg::CTRL_MP_FILT];
    assign bus.done_flag = s.status[nbu_pkg::STAT_RX_DONE];

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // Data write while idle begins a start bit next cycle
    a_tx_start: assert property (
        (tx_load && !tx_busy)
        |=> s.tx_state == nbu_pkg::SEQ_START && !txd)
        else $error("data write did not start a frame");

    // Transmit done rises together with the stop bit
    a_txdone_stop: assert property (
        (s.tx_state == nbu_pkg::SEQ_DATA && tx_set)
        |=> s.tx_state == nbu_pkg::SEQ_STOP && txd &&
            s.status[nbu_pkg::STAT_TX_DONE])
        else $error("transmit done not set at stop bit");

    // Start bit low, stop bit high
    a_frame_levels: assert property (
        (s.tx_state == nbu_pkg::SEQ_START && !txd) or
        (s.tx_state == nbu_pkg::SEQ_STOP && txd) or
        (s.tx_state == nbu_pkg::SEQ_IDLE && txd) or
        (s.tx_state == nbu_pkg::SEQ_DATA))
        else $error("line level wrong for frame phase");

    // Ninth bit slot carries the captured control bit
    a_ninth_out: assert property (
        (s.tx_state == nbu_pkg::SEQ_DATA &&
         s.tx_bit == nbu_pkg::BIT_LAST) |-> txd == s.tx_ninth)
        else $error("ninth bit slot carries wrong value");

    // Accepted frame loads buffer and sets receive done
    a_rx_load: assert property (
        bus.accept |=> s.rx_buf == $past(bus.data) &&
                       s.rx_ninth == $past(bus.ninth) &&
                       s.status[nbu_pkg::STAT_RX_DONE])
        else $error("accepted frame not stored");

    // Without acceptance buffer and ninth bit hold
    a_rx_hold: assert property (
        !bus.accept |=> $stable(s.rx_buf) && $stable(s.rx_ninth))
        else $error("receive buffer changed without accept");

    // A flag set under an unchanged open mask raises the interrupt
    a_irq_level: assert property (
        ((tx_set && s.mask[nbu_pkg::STAT_TX_DONE]) ||
         (bus.accept && s.mask[nbu_pkg::STAT_RX_DONE]))
        |=> irq || s.mask != $past(s.mask))
        else $error("interrupt not raised by an enabled flag");

    // Write response held until taken
    a_bvalid_hold: assert property (
        (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid)
        else $error("write response dropped before ready");

endmodule

//--- verif/nbu_peer.sv
// Far-side serial partner: sends frames on rxd and captures frames on txd
`timescale 1ns/10ps
module nbu_peer #(
    parameter int BIT_CYC = 16  // Clock cycles per bit
) (
    input  wire logic aclk,     // System clock
    input  wire logic txd,      // Line from the block
    output logic      rxd       // Line into the block, idle high
);
    logic [7:0] got_byte;       // Last captured byte
    logic       got_ninth;      // Last captured ninth bit
    int         got_count;      // Frames captured so far
    logic [9:0] sh;             // Captured bits, stop last
    int         i;              // Bit counter of the capture

    // Idle line and empty capture at start
    initial
    begin
        rxd = 1'b1;
        got_count = 0;
    end

    // Sends one frame: start, LSB first, ninth bit, chosen stop level
    task automatic send(input logic [7:0] b, input logic n9, input logic stp);
        logic [10:0] f;
        f = {stp, n9, b, 1'h0};
        for (int k = 0; k < 11; k++)
        begin
            rxd <= f[k];
            repeat (BIT_CYC) @(posedge aclk);
        end
        rxd <= 1'b1;
    endtask

    // Captures frames on txd, sampling each bit in its middle
    always
    begin
        @(negedge txd);
        repeat (BIT_CYC / 2) @(posedge aclk);
        for (i = 0; i < 10; i++)
        begin
            repeat (BIT_CYC) @(posedge aclk);
            sh[i] = txd;
        end
        got_byte = sh[7:0];
        got_ninth = sh[8];
        got_count++;
    end
endmodule

//--- verif/nbu_top_tb.sv
// Self-checking bench for the nine-bit serial port
`timescale 1ns/10ps
module nbu_top_tb;
    logic        aclk, aresetn, irq, txd, rxd;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, rs;
    int          mismatches, checks, cnt, n;

    typedef struct packed {
        logic       clr;
        logic [2:0] ctrl;
        logic [7:0] b;
        logic       n9;
        logic       stp;
        logic [7:0] ed;
        logic       en9;
        logic       edone;
    } nbu_row_type;

    // Receive cases: clear, control, frame sent, expected buffer state
    nbu_row_type rows [6] = '{
        '{1'h0, 3'h1, 8'hA5, 1'h1, 1'h0, 8'hA5, 1'h1, 1'h1},
        '{1'h0, 3'h1, 8'h3C, 1'h0, 1'h1, 8'hA5, 1'h1, 1'h1},
        '{1'h1, 3'h0, 8'h77, 1'h0, 1'h1, 8'hA5, 1'h1, 1'h0},
        '{1'h0, 3'h3, 8'h11, 1'h0, 1'h1, 8'hA5, 1'h1, 1'h0},
        '{1'h0, 3'h3, 8'h22, 1'h1, 1'h1, 8'h22, 1'h1, 1'h1},
        '{1'h1, 3'h1, 8'h81, 1'h0, 1'h1, 8'h81, 1'h0, 1'h1}};
    logic [7:0]  raddr [5] = '{8'h00, 8'h04, 8'h08, 8'h14, 8'h18};
    logic [31:0] rval [5] = '{32'h0, 32'h0, 32'h0, 32'h36, 32'h0};
    logic [7:0]  txb [2] = '{8'h96, 8'h07};

    nbu_top u_dut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .rxd(rxd), .txd(txd), .irq(irq));
    nbu_peer u_peer (.aclk(aclk), .txd(txd), .rxd(rxd));

    // 100 MHz clock
    initial aclk = 1'b0;
    always #5 aclk = ~aclk;

    // Prints the verdict and ends the run
    task automatic tally_and_finish;
        if (mismatches == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Compares one value and reports a mismatch
    task automatic check(input string nm, input logic [31:0] e,
                         input logic [31:0] g);
        checks++;
        if (g !== e)
        begin
            mismatches++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    // One cycle of a bounded wait; the run ends when the bound is used up
    task automatic tick(input int lim);
        @(posedge aclk);
        n++;
        if (n > lim)
        begin
            mismatches++;
            tally_and_finish();
        end
    endtask

    // AXI4-Lite write; address and data offered together
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic pa, pw;
        pa = 1'b1;
        pw = 1'b1;
        n = 0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (pa || pw || !bvalid)
        begin
            tick(50);
            if (pa && awready)
            begin
                awvalid <= 1'b0;
                pa = 1'b0;
            end
            if (pw && wready)
            begin
                wvalid <= 1'b0;
                pw = 1'b0;
            end
        end
        rs = bresp;
    endtask

    // AXI4-Lite read
    task automatic rd_reg(input logic [7:0] a);
        n = 0;
        araddr <= a;
        arvalid <= 1'b1;
        do tick(50); while (!arready);
        arvalid <= 1'b0;
        do tick(50); while (!rvalid);
        rd = rdata;
        rs = rresp;
    endtask

    // Main sequence
    initial
    begin
        {aresetn, awvalid, wvalid, arvalid, awaddr, araddr, wdata} = '0;
        {bready, rready, wstrb, mismatches, checks} = {2'h3, 4'hF, 64'h0};
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (3) @(posedge aclk);
        wr(nbu_pkg::ADDR_BAUD, 32'h0);
        foreach (rows[k])
        begin
            if (rows[k].clr)
                wr(nbu_pkg::ADDR_STATUS, 32'h2);
            wr(nbu_pkg::ADDR_CTRL, {29'h0, rows[k].ctrl});
            u_peer.send(rows[k].b, rows[k].n9, rows[k].stp);
            rd_reg(nbu_pkg::ADDR_DATA);
            check("rx data", {24'h0, rows[k].ed}, rd);
            rd_reg(nbu_pkg::ADDR_RXINFO);
            check("rx ninth", {31'h0, rows[k].en9}, rd);
            rd_reg(nbu_pkg::ADDR_STATUS);
            check("rx done", {30'h0, rows[k].edone, 1'h0}, rd);
        end
        // Receive done raises the interrupt once unmasked
        wr(nbu_pkg::ADDR_MASK, 32'h2);
        repeat (2) @(posedge aclk);
        check("irq rx done", 32'h1, {31'h0, irq});
        // Reset in mid-run, then reset values and an unmapped place
        aresetn <= 1'b0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (3) @(posedge aclk);
        check("irq reset", 32'h0, {31'h0, irq});
        check("txd idle", 32'h1, {31'h0, txd});
        for (int k = 0; k < 5; k++)
        begin
            rd_reg(raddr[k]);
            check("reset value", rval[k], rd);
            check("read resp", (k == 4) ? 32'h2 : 32'h0, {30'h0, rs});
        end
        wr(8'h18, 32'hFF);
        check("write resp", 32'h2, {30'h0, rs});
        wr(nbu_pkg::ADDR_BAUD, 32'h0);
        wr(nbu_pkg::ADDR_MASK, 32'h1);
        // Transmit with parity as the ninth bit
        foreach (txb[k])
        begin
            cnt = u_peer.got_count;
            wr(nbu_pkg::ADDR_CTRL, {29'h0, ^txb[k], 2'h0});
            wr(nbu_pkg::ADDR_DATA, {24'h0, txb[k]});
            n = 0;
            while (irq !== 1'h1)
                tick(400);
            check("txd at done", 32'h1, {31'h0, txd});
            check("frames at done", cnt, u_peer.got_count);
            n = 0;
            while (u_peer.got_count == cnt)
                tick(100);
            check("tx byte", 32'(txb[k]), 32'(u_peer.got_byte));
            check("tx ninth", 32'(^txb[k]), 32'(u_peer.got_ninth));
            wr(nbu_pkg::ADDR_STATUS, 32'h1);
            repeat (2) @(posedge aclk);
            check("irq clear", 32'h0, {31'h0, irq});
            rd = 32'h2;
            for (int j = 0; j < 20 && rd[1]; j++)
                rd_reg(nbu_pkg::ADDR_RXINFO);
            check("tx busy", 32'h0, rd & 32'h2);
        end
        // Masked flag stays set and raises the interrupt once unmasked
        wr(nbu_pkg::ADDR_MASK, 32'h0);
        cnt = u_peer.got_count;
        wr(nbu_pkg::ADDR_DATA, 32'h5A);
        n = 0;
        while (u_peer.got_count == cnt)
            tick(400);
        check("irq masked", 32'h0, {31'h0, irq});
        rd_reg(nbu_pkg::ADDR_STATUS);
        check("tx done sticky", 32'h1, rd);
        wr(nbu_pkg::ADDR_MASK, 32'h1);
        repeat (2) @(posedge aclk);
        check("irq unmasked", 32'h1, {31'h0, irq});
        tally_and_finish();
    end
endmodule
